// ### src/nhf_host.sv
// Host controller that fills and drains the external 64 x 4 handshake FIFO
module nhf_host
  import nhf_pkg::*;
(
  input  wire logic                    clk,       // 10 MHz system clock
  input  wire logic                    reset,     // Asynchronous reset, active high
  // Producer side user port
  input  wire logic                    wr_valid,  // User offers a nibble
  input  wire logic [NHF_NIBBLE_W-1:0] wr_data,   // Nibble to push
  output logic                         wr_ready,  // One-cycle pulse: nibble accepted
  // Consumer side user port
  output logic                         rd_valid,  // Popped nibble available
  output logic      [NHF_NIBBLE_W-1:0] rd_data,   // Popped nibble
  input  wire logic                    rd_ready,  // User takes the nibble
  // Buffer pins
  input  wire nhf_pins_in_s            pins_in,   // Status and data from the buffer
  output nhf_pins_out_s                pins_out   // Strobes and data toward the buffer
);

  nhf_pins_in_s  pin_s;         // Synchronised copy of the buffer pins
  nhf_wstate_e   wstate;
  nhf_wstate_e   next_wstate;
  nhf_rstate_e   rstate;
  nhf_rstate_e   next_rstate;
  logic                    push;          // Registered push strobe toward the buffer
  logic                    pop;           // Registered pop strobe toward the buffer
  logic [NHF_NIBBLE_W-1:0] write_nibble;  // Registered nibble on the data pins
  logic                    next_push;
  logic                    next_pop;
  logic [NHF_NIBBLE_W-1:0] next_write_nibble;
  logic                    next_wr_ready;
  logic                    next_rd_valid;
  logic [NHF_NIBBLE_W-1:0] next_rd_data;

  // Buffer pins change with no relation to clk, so every one is resynchronised
  nhf_sync #(
    .W (NHF_SYNC_W)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (pins_in),
    .q     (pin_s)
  );

  // Write side: present nibble, raise push, wait for capture, drop push, wait release
  always_comb begin
    next_wstate       = wstate;
    next_push         = push;
    next_write_nibble = write_nibble;
    next_wr_ready     = NHF_LOW;
    case (wstate)
      NHF_W_IDLE: begin
        // Full buffer holds free-slot low, so nothing is offered then
        if (wr_valid && pin_s.free_slot) begin
          next_write_nibble = wr_data;
          next_wr_ready     = NHF_HIGH;
          next_wstate       = NHF_W_SETUP;
        end
      end
      NHF_W_SETUP: begin
        // One cycle of data setup before the strobe
        next_push   = NHF_HIGH;
        next_wstate = NHF_W_PUSH;
      end
      NHF_W_PUSH: begin
        // Free-slot falling marks the capture; only then may push drop
        if (!pin_s.free_slot) begin
          next_push   = NHF_LOW;
          next_wstate = NHF_W_RELEASE;
        end
      end
      NHF_W_RELEASE: begin
        // Both lines now low; the buffer ripples the nibble inward on its own
        next_wstate = NHF_W_IDLE;
      end
      default: begin
        next_push   = NHF_LOW;
        next_wstate = NHF_W_IDLE;
      end
    endcase
  end

  // Write side registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wstate       <= NHF_W_IDLE;
      push         <= NHF_LOW;
      write_nibble <= NHF_NIBBLE_RST;
      wr_ready     <= NHF_LOW;
    end else begin
      wstate       <= next_wstate;
      push         <= next_push;
      write_nibble <= next_write_nibble;
      wr_ready     <= next_wr_ready;
    end
  end

  // Pin bundle has a single driver; every field is a write-side or read-side flip-flop
  assign pins_out = {push, pop, write_nibble};

  // Read side: on word-valid capture the nibble and pop, then wait for both lines low
  always_comb begin
    next_rstate   = rstate;
    next_pop      = pop;
    next_rd_valid = rd_valid;
    next_rd_data  = rd_data;
    if (rd_valid && rd_ready) begin
      next_rd_valid = NHF_LOW;
    end
    case (rstate)
      NHF_R_IDLE: begin
        // Data settles before word-valid, so the synchronised nibble is steady here.
        // Popping waits for an empty holding register; the buffer absorbs the stall.
        if (pin_s.word_valid && !rd_valid) begin
          next_rd_data  = pin_s.read_nibble;
          next_rd_valid = NHF_HIGH;
          next_pop      = NHF_HIGH;
          next_rstate   = NHF_R_POP;
        end
      end
      NHF_R_POP: begin
        // Word-valid falling means the output nibble was removed
        if (!pin_s.word_valid) begin
          next_pop    = NHF_LOW;
          next_rstate = NHF_R_RELEASE;
        end
      end
      NHF_R_RELEASE: begin
        // Empty buffer keeps word-valid low, so idle simply waits for it
        next_rstate = NHF_R_IDLE;
      end
      default: begin
        next_pop    = NHF_LOW;
        next_rstate = NHF_R_IDLE;
      end
    endcase
  end

  // Read side registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rstate       <= NHF_R_IDLE;
      pop          <= NHF_LOW;
      rd_valid     <= NHF_LOW;
      rd_data      <= NHF_NIBBLE_RST;
    end else begin
      rstate       <= next_rstate;
      pop          <= next_pop;
      rd_valid     <= next_rd_valid;
      rd_data      <= next_rd_data;
    end
  end

  // Checks on the pin handshakes
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_accept;
    wr_ready;
  endsequence

  sequence s_push_raised;
    pins_out.push && $stable(pins_out.write_nibble);
  endsequence

  sequence s_pop_start;
    $rose(pins_out.pop);
  endsequence

  // Accepted nibble reaches the pins with a setup cycle, then push rises
  accept_then_push_a: assert property (s_accept |-> !pins_out.push ##1 s_push_raised)
    else $error("push did not follow acceptance by one cycle");

  // Push never starts while the buffer reports no free slot
  push_needs_free_a: assert property ($rose(pins_out.push) |-> $past(pin_s.free_slot, 2))
    else $error("push raised without a free slot");

  // Nibble is held while push stands
  nibble_hold_a: assert property (pins_out.push |-> $stable(pins_out.write_nibble))
    else $error("write nibble changed under push");

  // Push drops exactly one cycle after free-slot is seen low
  push_release_a: assert property (pins_out.push && !pin_s.free_slot |=> !pins_out.push)
    else $error("push not released after capture");

  // Push stays high until capture is seen
  push_persist_a: assert property (pins_out.push && pin_s.free_slot |=> pins_out.push)
    else $error("push dropped before capture");

  // Pop begins only on word-valid and captures that cycle's nibble
  pop_capture_a: assert property (s_pop_start |-> $past(pin_s.word_valid)
                                   && rd_valid && rd_data == $past(pin_s.read_nibble))
    else $error("pop without word-valid or wrong nibble captured");

  // Pop drops one cycle after word-valid falls and stays low for the release cycle
  pop_release_a: assert property (pins_out.pop && !pin_s.word_valid
                                   |=> !pins_out.pop [*2])
    else $error("pop not released after removal");

  // Pop holds until the removal is seen
  pop_persist_a: assert property (pins_out.pop && pin_s.word_valid |=> pins_out.pop)
    else $error("pop dropped before removal");

  // Empty buffer never draws a pop
  no_empty_pop_a: assert property (!pin_s.word_valid && !pins_out.pop
                                    |=> !pins_out.pop)
    else $error("pop raised on an empty buffer");

  // Popped nibble stays put until the user takes it
  rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read nibble lost before being taken");

endmodule : nhf_host

// ### src/nhf_pkg.sv
// Shared constants, pin bundles and state types for the nibble FIFO host controller
package nhf_pkg;

  // Geometry of the external buffer
  localparam int unsigned NHF_DEPTH    = 64;
  localparam int unsigned NHF_NIBBLE_W = 4;
  localparam int unsigned NHF_SYNC_W   = NHF_NIBBLE_W + 2;

  // Reset values
  localparam logic [NHF_NIBBLE_W-1:0] NHF_NIBBLE_RST = 4'h0;
  localparam logic                    NHF_LOW        = 1'b0;
  localparam logic                    NHF_HIGH       = 1'b1;

  // Pins driven by the host into the buffer
  typedef struct packed {
    logic                    push;          // Push strobe, active high
    logic                    pop;           // Pop strobe, active high
    logic [NHF_NIBBLE_W-1:0] write_nibble;  // Bit 3 is write_nibble_bit3, bit 0 write_nibble_bit0
  } nhf_pins_out_s;

  // Pins driven by the buffer toward the host
  typedef struct packed {
    logic                    free_slot;     // Entry stage can take a nibble
    logic                    word_valid;    // Output position holds a nibble
    logic [NHF_NIBBLE_W-1:0] read_nibble;   // Nibble at the output position
  } nhf_pins_in_s;

  // Write side handshake states
  typedef enum logic [1:0] {
    NHF_W_IDLE,
    NHF_W_SETUP,
    NHF_W_PUSH,
    NHF_W_RELEASE
  } nhf_wstate_e;

  // Read side handshake states
  typedef enum logic [1:0] {
    NHF_R_IDLE,
    NHF_R_POP,
    NHF_R_RELEASE
  } nhf_rstate_e;

endpackage : nhf_pkg

// ### src/nhf_sync.sv
// Two-stage synchroniser for buffer status and data pins
module nhf_sync
  import nhf_pkg::*;
#(
  parameter int unsigned W = NHF_SYNC_W
) (
  input  wire logic         clk,    // System clock
  input  wire logic         reset,  // Asynchronous reset, active high
  input  wire logic [W-1:0] d,      // Asynchronous input
  output logic      [W-1:0] q       // Synchronised output
);

  logic [W-1:0] stage1;

  // First stage feeds only the second; nothing else may look at it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : nhf_sync

// ### verification/nhf_fifo_model.sv
// Behavioural model of the 64 x 4 handshake FIFO that the host drives
module nhf_fifo_model
  import nhf_pkg::*;
(
  input  wire nhf_pins_out_s pins_out,  // Strobes and data from the host
  output nhf_pins_in_s       pins_in,   // Status and data toward the host
  input  wire logic [31:0]   delay_ns   // Internal settle time, prompt or slow
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [NHF_NIBBLE_W-1:0] q[$];   // Stored nibbles, oldest first
  logic [NHF_NIBBLE_W-1:0] entry;  // Entry stage
  int                      count;  // Occupancy
  // Write side runs on its own, blind to the read side timing
  initial begin
    pins_in.free_slot = NHF_HIGH;
    count = 0;
    forever begin
      wait (pins_in.free_slot === 1'b1 && pins_out.push === 1'b1);
      entry = pins_out.write_nibble;
      #(delay_ns) pins_in.free_slot = NHF_LOW;
      wait (pins_out.push === 1'b0);
      #(delay_ns) q.push_back(entry);
      count = count + 1;
      // No room means no new free slot
      wait (count < NHF_DEPTH);
      pins_in.free_slot = NHF_HIGH;
    end
  end
  // Read side: present, remove on pop, refill once both lines are low
  initial begin
    pins_in.word_valid = NHF_LOW;
    pins_in.read_nibble = 4'hA;
    forever begin
      wait (count > 0);
      #(delay_ns) pins_in.read_nibble = q[0];
      #1 pins_in.word_valid = NHF_HIGH;
      wait (pins_out.pop === 1'b1);
      #(delay_ns) pins_in.word_valid = NHF_LOW;
      // Released data lines must not look like the last nibble
      pins_in.read_nibble = ~pins_in.read_nibble;
      void'(q.pop_front());
      count = count - 1;
      wait (pins_out.pop === 1'b0);
    end
  end
endmodule : nhf_fifo_model

// ### verification/tb_top.sv
// Self-checking bench for the nibble FIFO host controller
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import nhf_pkg::*;
  logic          clk, reset, wr_valid, wr_ready, rd_valid, rd_ready, ok;
  logic [3:0]    wr_data, rd_data;
  logic [31:0]   delay_ns;
  nhf_pins_in_s  pins_in;
  nhf_pins_out_s pins_out;
  int            failures, num_checks;

  nhf_host u_dut (.clk(clk), .reset(reset), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
    .pins_in(pins_in), .pins_out(pins_out));
  nhf_fifo_model u_fifo (.pins_out(pins_out), .pins_in(pins_in), .delay_ns(delay_ns));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [5:0] exp, input logic [5:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Offer one nibble; bounded so a refused offer still returns
  task automatic put(input logic [3:0] d, output logic acc);
    acc = 1'b0;
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data = d;
    repeat (300) begin
      @(negedge clk);
      if (wr_ready === 1'b1) begin
        acc = 1'b1;
        break;
      end
    end
    wr_valid = 1'b0;
  endtask : put

  // Take one nibble and compare it
  task automatic get(input logic [3:0] e);
    int n;
    n = 0;
    @(negedge clk);
    rd_ready = 1'b1;
    while (rd_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("rd_valid", 6'h01, 6'(rd_valid));
    check("rd_data", 6'(e), 6'(rd_data));
    @(negedge clk);
    rd_ready = 1'b0;
  endtask : get

  // Reset clears rd_valid and leaves no strobe or nibble on the pins
  task automatic test_reset;
    reset = 1'b1;
    {wr_valid, rd_ready, wr_data, delay_ns, failures, num_checks} = '0;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    check("pins_out", 6'h00, pins_out);
    check("rd_valid", 6'h00, 6'(rd_valid));
    $display("test reset done");
  endtask : test_reset

  task automatic test_order(input int n, input logic [31:0] dly);
    delay_ns = dly;
    for (int i = 0; i < n; i++) begin
      put(4'(i * 7), ok);
      check("wr_ready", 6'h01, 6'(ok));
    end
    for (int i = 0; i < n; i++) get(4'(i * 7));
    $display("test order of %0d with delay %0d done", n, dly);
  endtask : test_order

  // Host keeps one nibble, so 65 go in before the buffer refuses
  task automatic test_full;
    delay_ns = 32'd50;
    for (int i = 0; i < 65; i++) begin
      put(~4'(i), ok);
      check("wr_ready", 6'h01, 6'(ok));
    end
    put(4'h3, ok);
    check("refused", 6'h00, 6'(ok));
    check("free_slot", 6'h00, 6'(pins_in.free_slot));
    for (int i = 0; i < 65; i++) get(~4'(i));
    repeat (20) @(negedge clk);
    check("rd_valid idle", 6'h00, 6'(rd_valid));
    check("word_valid idle", 6'h00, 6'(pins_in.word_valid));
    $display("test full done");
  endtask : test_full

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Cut a hang short well beyond the expected run time
  initial begin
    #5000000;
    failures++;
    final_report();
  end

  initial begin
    test_reset();
    test_order(16, 32'd50);
    test_full();
    test_order(3, 32'd700);
    final_report();
  end
endmodule : tb_top
